/* dv/phyevt_checker.sv */
// Port checker for the event flag block.
// Assumes a bind onto phyevt_flags.
`timescale 1ns/10ps
module phyevt_checker (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic FCS_HALF_PULSE,
  input wire logic RXERR_HALF_PULSE,
  input wire logic FLAG_READ,
  input wire logic EN_WRITE,
  input wire phyevt_pkg::phyevt_word_t EN_WDATA,
  input wire phyevt_pkg::phyevt_word_t FLAGS,
  input wire phyevt_pkg::phyevt_word_t ENABLES,
  input wire logic IRQ
);
  import phyevt_pkg::*;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  AST_FCS: assert property (CE && FCS_HALF_PULSE |=> FLAGS[9]) else $error("fcs");
  AST_RXE: assert property (CE && RXERR_HALF_PULSE |=> FLAGS[8]) else $error("rxe");
  AST_CLR: assert property (CE && FLAG_READ && !FCS_HALF_PULSE |=> !FLAGS[9])
    else $error("clear");
  AST_KEEP: assert property (FLAGS[8] && !(CE && FLAG_READ) |=> FLAGS[8]) else $error("keep");
  AST_ENW: assert property (CE && EN_WRITE |=> ENABLES == $past(EN_WDATA)) else $error("en");
  AST_IRQ: assert property (IRQ == |(FLAGS & ENABLES)) else $error("irq");
  AST_HOLD: assert property (!CE |=> $stable(FLAGS) && $stable(ENABLES)) else $error("hold");
  AST_RST: assert property ($rose(RST_N) |-> ENABLES == 16'h0000 && FLAGS == 16'h0000)
    else $error("reset");
endmodule
bind phyevt_flags phyevt_checker chk (.*);

/* dv/tb.sv */
// Self-checking bench for the event flag block.
// Assumes design files and checker are compiled first.
`timescale 1ns/10ps
module tb;
  import phyevt_pkg::*;
  logic clock = 0, rst_n = 0, ce = 1, fcs = 0, rxe = 0, rd = 0, enw = 0, irq;
  logic [5:0] lv = '0;
  logic [1:0] pr;
  phyevt_word_t wd = '0, flags, ens;
  int errors = 0, n_tests = 0;
  int pos[6] = '{13, 14, 15, 12, 11, 10};
  always #10 clock = ~clock;
  phyevt_flags dut (.CLOCK(clock), .RST_N(rst_n), .CE(ce), .LINK_UP(lv[0]),
    .ENERGY_LEVEL(lv[1]), .QUALITY_GOOD(lv[2]), .SPEED_100(lv[3]), .FULL_DUPLEX(lv[4]),
    .ANEG_DONE(lv[5]), .FCS_HALF_PULSE(fcs), .RXERR_HALF_PULSE(rxe), .FLAG_READ(rd),
    .EN_WRITE(enw), .EN_WDATA(wd), .FLAGS(flags), .ENABLES(ens), .IRQ(irq));
  //////////////////////////////////////////////////
  task automatic chk(string nm, phyevt_word_t e, phyevt_word_t g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic want_irq(phyevt_word_t f, phyevt_word_t e);
    return |(f & e);
  endfunction
  task automatic cyc(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic clr();
    @(posedge clock) rd <= 1;
    @(posedge clock) rd <= 0;
    #1 chk("cleared", '0, flags);
  endtask
  task automatic wrap_up();
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  //////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h7a883691));
    repeat (5) @(posedge clock);
    rst_n <= 1;
    cyc(1);
    // Link first, so quality is seen with the link up
    for (int i = 0; i < 6; i++) begin
      @(posedge clock) lv[i] <= 1;
      cyc(6);
      chk("level", 16'h0001 << pos[i], flags);
      clr();
    end
    @(posedge clock) lv[0] <= 0;
    cyc(6);
    clr();
    @(posedge clock) lv[2] <= 0;
    cyc(6);
    chk("quality down", '0, flags);
    $display("levels done");
    @(posedge clock) rxe <= 1;
    @(posedge clock) begin ce <= 0; fcs <= 1; rxe <= 0; end
    @(posedge clock) begin ce <= 1; rd <= 1; end
    @(posedge clock) begin fcs <= 0; rd <= 0; end
    #1 chk("read race", 16'h0200, flags);
    clr();
    $display("race done");
    repeat (20) begin
      pr = 2'($urandom);
      @(posedge clock) begin enw <= 1; wd <= 16'($urandom); {fcs, rxe} <= pr; end
      @(posedge clock) begin enw <= 0; fcs <= 0; rxe <= 0; end
      cyc(1);
      chk("flags", {6'h00, pr, 8'h00}, flags);
      chk("enables", wd, ens);
      chk("irq", {15'h0000, want_irq({6'h00, pr, 8'h00}, wd)}, {15'h0000, irq});
      clr();
    end
    $display("random done");
    wrap_up();
  end
  initial begin
    #100us;
    errors++;
    wrap_up();
  end
endmodule

/* rtl/phyevt_defines.svh */
// Bit positions and reset values of the event flag and enable words.
// Assumes inclusion by the flag block only; the event detector does not include it.
`ifndef PHYEVT_DEFINES_SVH
`define PHYEVT_DEFINES_SVH
`define PHYEVT_BIT_QUAL 4'd15
`define PHYEVT_BIT_ENERGY 4'd14
`define PHYEVT_BIT_LINK 4'd13
`define PHYEVT_BIT_SPEED 4'd12
`define PHYEVT_BIT_DUPLEX 4'd11
`define PHYEVT_BIT_ANEG 4'd10
`define PHYEVT_BIT_FCS_HALF 4'd9
`define PHYEVT_BIT_RXERR_HALF 4'd8
`define PHYEVT_FLAG_RESET 16'h0000
`define PHYEVT_EN_RESET 16'h0000
`define PHYEVT_FCS_ADDR 16'h0014
`define PHYEVT_RXERR_ADDR 16'h0015
`endif

/* rtl/phyevt_edge.sv */
// Change detector for one status level, with optional pin synchroniser.
// Assumes the level is either from this clock or an asynchronous pin.
`timescale 1ns/10ps
module phyevt_edge #(
  parameter int SYNC = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic level_in,
  output logic change
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic seen_r;
  logic cur;
  // Change counts once second and third stages agree
  assign cur = (SYNC != 0) ? s3_r : level_in;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      seen_r <= 1'b0;
    end else if (ce) begin
      s1_r <= level_in;
      s2_r <= s1_r;
      if ((SYNC == 0) || (s2_r == s3_r)) begin
        seen_r <= cur;
      end
      s3_r <= s2_r;
    end
  end
  assign change = ce && (((SYNC == 0) || (s2_r == s3_r)) ? (cur != seen_r) : 1'b0);
endmodule

/* rtl/phyevt_flags.sv */
// Sticky event flags, enables and interrupt output of the PHY event logic.
// Assumes status levels arrive as pins; counter half-full inputs are pulses
// from core logic; flag reads arrive as a one-cycle read strobe.
// Notes on behaviour
// - Energy-detect status change sets flag bit 14.
// - Link status change sets flag bit 13.
// - Link quality change sets flag bit 15 only while the link is up.
// - Speed status change sets the speed flag.
// - Duplex status change sets the duplex flag.
// - Auto-negotiation completion sets its flag.
// - False-carrier counter passing half-full sets its flag.
// - Receive-error counter passing half-full sets its flag.
// - Link quality interrupt only raised when its enable is set.
// - Link status interrupt gated by its enable.
// - Duplex interrupt gated by its enable, reset to 0.
// - Auto-negotiation interrupt gated by its enable, reset to 0.
// - Receive-error half-full interrupt gated by its enable.
// - Link quality flag sits at bit 15, reset 0.
// - Speed flag sits at bit 12, reset 0.
`timescale 1ns/10ps
`include "phyevt_defines.svh"
module phyevt_flags (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic ENERGY_LEVEL,
  input wire logic LINK_UP,
  input wire logic QUALITY_GOOD,
  input wire logic SPEED_100,
  input wire logic FULL_DUPLEX,
  input wire logic ANEG_DONE,
  input wire logic FCS_HALF_PULSE,
  input wire logic RXERR_HALF_PULSE,
  input wire logic FLAG_READ,
  input wire logic EN_WRITE,
  input wire phyevt_pkg::phyevt_word_t EN_WDATA,
  output phyevt_pkg::phyevt_word_t FLAGS,
  output phyevt_pkg::phyevt_word_t ENABLES,
  output logic IRQ
);
  import phyevt_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [4:0] lvl;
  logic [4:0] chg;
  logic link_sync_r1;
  logic link_sync_r2;
  logic link_sync_r3;
  logic link_now_r;
  phyevt_word_t set_vec;
  phyevt_word_t flags_r;
  phyevt_word_t flags_nxt;
  phyevt_word_t en_r;
  phyevt_word_t en_nxt;
  logic irq_r;
  logic irq_nxt;

  // 0 energy, 1 link, 2 quality, 3 speed, 4 duplex
  assign lvl = {FULL_DUPLEX, SPEED_100, QUALITY_GOOD, LINK_UP, ENERGY_LEVEL};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_edge
      phyevt_edge #(.SYNC(1)) u_edge (
        .clk(CLOCK),
        .rst_n(RST_N),
        .ce(CE),
        .level_in(lvl[gi]),
        .change(chg[gi])
      );
    end
  endgenerate

  // Own synchroniser for the link gate; quality qualified by agreed level
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      link_sync_r1 <= 1'b0;
      link_sync_r2 <= 1'b0;
      link_sync_r3 <= 1'b0;
      link_now_r <= 1'b0;
    end else if (CE) begin
      link_sync_r1 <= LINK_UP;
      link_sync_r2 <= link_sync_r1;
      link_sync_r3 <= link_sync_r2;
      if (link_sync_r2 == link_sync_r3) begin
        link_now_r <= link_sync_r3;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  logic aneg_s1_r;
  logic aneg_s2_r;
  logic aneg_s3_r;
  logic aneg_seen_r;
  logic aneg_rise;
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      aneg_s1_r <= 1'b0;
      aneg_s2_r <= 1'b0;
      aneg_s3_r <= 1'b0;
      aneg_seen_r <= 1'b0;
    end else if (CE) begin
      aneg_s1_r <= ANEG_DONE;
      aneg_s2_r <= aneg_s1_r;
      aneg_s3_r <= aneg_s2_r;
      if (aneg_s2_r == aneg_s3_r) begin
        aneg_seen_r <= aneg_s3_r;
      end
    end
  end
  // Completion is the agreed rising edge only
  assign aneg_rise = CE && (aneg_s2_r == aneg_s3_r) && aneg_s3_r && !aneg_seen_r;

  always_comb begin
    set_vec = 16'h0000;
    set_vec[`PHYEVT_BIT_ENERGY] = chg[0];
    set_vec[`PHYEVT_BIT_LINK] = chg[1];
    set_vec[`PHYEVT_BIT_QUAL] = chg[2] && link_now_r;
    set_vec[`PHYEVT_BIT_SPEED] = chg[3];
    set_vec[`PHYEVT_BIT_DUPLEX] = chg[4];
    set_vec[`PHYEVT_BIT_ANEG] = aneg_rise;
    set_vec[`PHYEVT_BIT_FCS_HALF] = CE && FCS_HALF_PULSE;
    set_vec[`PHYEVT_BIT_RXERR_HALF] = CE && RXERR_HALF_PULSE;
  end

  ////////////////////////////////////////////////////////////////////////
  // Set wins over the read clear so no event is lost
  assign flags_nxt = ((CE && FLAG_READ) ? 16'h0000 : flags_r) | set_vec;

  // Enable write lands at the same edge as any flag update
  assign en_nxt = (CE && EN_WRITE) ? EN_WDATA : en_r;

  // Next flags and next enables, so the interrupt never lags a write
  assign irq_nxt = |(flags_nxt & en_nxt);

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      flags_r <= `PHYEVT_FLAG_RESET;
      en_r <= `PHYEVT_EN_RESET;
      irq_r <= 1'b0;
    end else if (CE) begin
      flags_r <= flags_nxt;
      en_r <= en_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign FLAGS = flags_r;
  assign ENABLES = en_r;
  assign IRQ = irq_r;
endmodule

/* rtl/phyevt_pkg.sv */
// Types shared by the event flag block.
// Assumes the defines header is compiled alongside.
package phyevt_pkg;
  typedef logic [15:0] phyevt_word_t;
endpackage
